/* src/cpu_peripheral_speed_select.sv */
// clock speed control register and per-unit period selection
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// [R01] master clear: all use 12 periods; set: cpu 6, unit bits become effective
// [R02] reset clears bits 7..1, bit 0 loads from the security config byte
// [R03] unit speed bits do nothing while the master bit is clear
// [R04] with master set, unit bit clear gives 6 periods, set gives 12
// [R05] bit 4 steers serial port only in modes 0 and 2
// [R06] bit 5 steers the counter array with the same gating and encoding as the timer bits
// [R07] master bit change applied only on divided-by-two clock rising edge
// [R08] reserved bit 7 reads zero, writes to it are ignored
module cpu_peripheral_speed_select
  import speed_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] security_config_byte,
  input wire logic [1:0] serial_port_mode,
  output logic double_speed_master,
  output logic [3:0] cpu_periods,
  output logic [3:0] watchdog_periods,
  output logic [3:0] counter_array_periods,
  output logic [3:0] serial_port_periods,
  output logic [3:0] timer_two_periods,
  output logic [3:0] timer_one_periods,
  output logic [3:0] timer_zero_periods
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic strap_taken;
    logic [7:0] control;
    logic master_applied;
    logic [7:0] rdata;
    logic [3:0] cpu_p;
    logic [3:0] wd_p;
    logic [3:0] pca_p;
    logic [3:0] si_p;
    logic [3:0] t2_p;
    logic [3:0] t1_p;
    logic [3:0] t0_p;
  } speed_state_t;

  speed_state_t state_reg;
  speed_state_t state_next;
  logic rst_n;
  logic div_rise;

  // unit periods: fast only while master is applied and the unit bit is clear
  function automatic logic [3:0] unit_periods(input logic master, input logic sel);
    unit_periods = (master && !sel) ? PERIODS_FAST : PERIODS_STANDARD; // [R03] [R04]
  endfunction

  // one decode shared by both strobes, so read and write never disagree
  function automatic logic addr_hit(input logic [7:0] addr);
    addr_hit = 1'b0;
    if (addr == CLOCK_SPEED_CONTROL_ADDR) begin
      addr_hit = 1'b1;
    end
  endfunction

  assign rst_n = state_reg.rst_sync[1];

  half_rate_strobe divider (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .rise_strobe(div_rise)
  );

  always_comb begin
    logic m;
    logic serial_fixed;
    m = 1'b0;
    serial_fixed = 1'b0;
    state_next = state_reg;
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    // strap caught on the first clock after release, not under reset
    if (rst_n && !state_reg.strap_taken) begin
      state_next.strap_taken = 1'b1;
      state_next.control = {CONTROL_UPPER_RESET,
        security_config_byte[DOUBLE_SPEED_MASTER_POS]}; // [R02]
    end else if (reg_write && addr_hit(reg_addr)) begin
      state_next.control = reg_wdata & WRITABLE_MASK; // [R08]
    end
    // glitch-free: the divided clock gates when the cpu rate may switch
    if (div_rise) begin
      state_next.master_applied = state_reg.control[DOUBLE_SPEED_MASTER_POS]; // [R07]
    end
    m = state_next.master_applied;
    state_next.cpu_p = m ? PERIODS_FAST : PERIODS_STANDARD; // [R01]
    state_next.wd_p = unit_periods(m, state_next.control[WATCHDOG_SPEED_POS]);
    state_next.pca_p = unit_periods(m, state_next.control[COUNTER_ARRAY_SPEED_POS]); // [R06]
    state_next.t2_p = unit_periods(m, state_next.control[TIMER_TWO_SPEED_POS]);
    state_next.t1_p = unit_periods(m, state_next.control[TIMER_ONE_SPEED_POS]);
    state_next.t0_p = unit_periods(m, state_next.control[TIMER_ZERO_SPEED_POS]);
    // other serial modes use their own baud source, so standard rate is shown
    serial_fixed = (serial_port_mode == SERIAL_MODE_SHIFT) ||
      (serial_port_mode == SERIAL_MODE_FIXED);
    state_next.si_p = unit_periods(m && serial_fixed,
      state_next.control[SERIAL_PORT_SPEED_POS]); // [R05]
    state_next.rdata = 8'h00;
    if (reg_read && addr_hit(reg_addr)) begin
      state_next.rdata = state_reg.control & WRITABLE_MASK; // [R08]
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '{rst_sync: 2'h0, strap_taken: 1'b0, control: 8'h00,
        master_applied: 1'b0, rdata: 8'h00, cpu_p: PERIODS_STANDARD,
        wd_p: PERIODS_STANDARD, pca_p: PERIODS_STANDARD, si_p: PERIODS_STANDARD,
        t2_p: PERIODS_STANDARD, t1_p: PERIODS_STANDARD, t0_p: PERIODS_STANDARD};
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign double_speed_master = state_reg.master_applied;
  assign cpu_periods = state_reg.cpu_p;
  assign watchdog_periods = state_reg.wd_p;
  assign counter_array_periods = state_reg.pca_p;
  assign serial_port_periods = state_reg.si_p;
  assign timer_two_periods = state_reg.t2_p;
  assign timer_one_periods = state_reg.t1_p;
  assign timer_zero_periods = state_reg.t0_p;

  cpu_rate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R01]
    cpu_periods == (double_speed_master ? PERIODS_FAST : PERIODS_STANDARD))
    else $error("cpu period does not follow master bit");
  // sampled rst_n keeps the release edge itself out of the load check
  strap_load_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R02]
    (rst_n && !state_reg.strap_taken) |=> state_reg.control ==
    {CONTROL_UPPER_RESET, $past(security_config_byte[DOUBLE_SPEED_MASTER_POS])})
    else $error("reset value not taken from strap");
  control_bit7_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
    !state_reg.control[RESERVED_POS]) else $error("reserved bit held a one");

  master_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R03]
    !double_speed_master |-> (watchdog_periods == PERIODS_STANDARD &&
    timer_zero_periods == PERIODS_STANDARD && timer_one_periods == PERIODS_STANDARD &&
    timer_two_periods == PERIODS_STANDARD && counter_array_periods == PERIODS_STANDARD &&
    serial_port_periods == PERIODS_STANDARD))
    else $error("unit fast while master clear");
  timer_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    (double_speed_master && !state_reg.control[TIMER_TWO_SPEED_POS]) |->
    timer_two_periods == PERIODS_FAST) else $error("timer two not fast");
  timer_one_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    (double_speed_master && !state_reg.control[TIMER_ONE_SPEED_POS]) |->
    timer_one_periods == PERIODS_FAST) else $error("timer one not fast");
  timer_zero_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    (double_speed_master && !state_reg.control[TIMER_ZERO_SPEED_POS]) |->
    timer_zero_periods == PERIODS_FAST) else $error("timer zero not fast");
  watchdog_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    (double_speed_master && !state_reg.control[WATCHDOG_SPEED_POS]) |->
    watchdog_periods == PERIODS_FAST) else $error("watchdog not fast");
  counter_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
    (double_speed_master && !state_reg.control[COUNTER_ARRAY_SPEED_POS]) |->
    counter_array_periods == PERIODS_FAST) else $error("counter array not fast");
  timer_two_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    state_reg.control[TIMER_TWO_SPEED_POS] |-> timer_two_periods == PERIODS_STANDARD)
    else $error("timer two fast with bit set");
  timer_one_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    state_reg.control[TIMER_ONE_SPEED_POS] |-> timer_one_periods == PERIODS_STANDARD)
    else $error("timer one fast with bit set");
  timer_zero_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    state_reg.control[TIMER_ZERO_SPEED_POS] |-> timer_zero_periods == PERIODS_STANDARD)
    else $error("timer zero fast with bit set");
  watchdog_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R04]
    state_reg.control[WATCHDOG_SPEED_POS] |-> watchdog_periods == PERIODS_STANDARD)
    else $error("watchdog fast with bit set");
  pca_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R06]
    (double_speed_master && state_reg.control[COUNTER_ARRAY_SPEED_POS]) |->
    counter_array_periods == PERIODS_STANDARD)
    else $error("counter array not standard when bit set");

  serial_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
    (serial_port_mode == 2'h1) |=> serial_port_periods == PERIODS_STANDARD)
    else $error("serial speed bit acted outside modes 0 and 2");
  serial_other_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
    (serial_port_mode == 2'h3) |=> serial_port_periods == PERIODS_STANDARD)
    else $error("serial speed bit acted in mode 3");
  serial_fast_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
    (double_speed_master && !state_reg.control[SERIAL_PORT_SPEED_POS] &&
    ($past(serial_port_mode) == SERIAL_MODE_SHIFT ||
    $past(serial_port_mode) == SERIAL_MODE_FIXED)) |->
    serial_port_periods == PERIODS_FAST) else $error("serial port not fast");
  serial_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R05]
    state_reg.control[SERIAL_PORT_SPEED_POS] |-> serial_port_periods == PERIODS_STANDARD)
    else $error("serial port fast with bit set");

  master_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R07]
    $changed(double_speed_master) |-> $past(div_rise))
    else $error("master switched off divided clock edge");
  master_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R07]
    $past(div_rise) |-> double_speed_master ==
    $past(state_reg.control[DOUBLE_SPEED_MASTER_POS])) else $error("master missed strobe");
  write_then_apply_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R07]
    (reg_write && addr_hit(reg_addr) && state_reg.strap_taken)
    |-> ##[1:3] double_speed_master == state_reg.control[DOUBLE_SPEED_MASTER_POS])
    else $error("master bit not applied in time");

  reserved_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
    $past(reg_read) |-> !reg_rdata[RESERVED_POS])
    else $error("reserved bit read as one");
  read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
    (reg_read && addr_hit(reg_addr)) |=> reg_rdata == $past(state_reg.control))
    else $error("read data differs from register");
  read_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R08]
    !(reg_read && addr_hit(reg_addr)) |=> reg_rdata == 8'h00)
    else $error("read data not zero without a mapped read");

  enter_fast_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(double_speed_master));
  leave_fast_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(double_speed_master));
  serial_fast_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    serial_port_periods == PERIODS_FAST);
  strap_fast_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    (rst_n && !state_reg.strap_taken) ##1 state_reg.control[DOUBLE_SPEED_MASTER_POS]);
  serial_gated_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    double_speed_master && state_reg.control == 8'h01 && serial_port_periods == PERIODS_STANDARD);
endmodule

/* src/speed_ctrl_pkg.sv */
// shared constants for the cpu and peripheral speed select block
package speed_ctrl_pkg;
  localparam logic [7:0] CLOCK_SPEED_CONTROL_ADDR = 8'h8F;
  localparam int DOUBLE_SPEED_MASTER_POS = 0;
  localparam int TIMER_ZERO_SPEED_POS = 1;
  localparam int TIMER_ONE_SPEED_POS = 2;
  localparam int TIMER_TWO_SPEED_POS = 3;
  localparam int SERIAL_PORT_SPEED_POS = 4;
  localparam int COUNTER_ARRAY_SPEED_POS = 5;
  localparam int WATCHDOG_SPEED_POS = 6;
  localparam int RESERVED_POS = 7;
  localparam logic [6:0] CONTROL_UPPER_RESET = 7'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'h7F;
  localparam logic [3:0] PERIODS_STANDARD = 4'hC;
  localparam logic [3:0] PERIODS_FAST = 4'h6;
  localparam logic [1:0] SERIAL_MODE_SHIFT = 2'h0;
  localparam logic [1:0] SERIAL_MODE_FIXED = 2'h2;
endpackage

/* src/half_rate_strobe.sv */
// divide-by-two phase strobe of the oscillator clock
`timescale 1ns/1ns
module half_rate_strobe (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic rise_strobe
);
  typedef struct packed {
    logic phase;
  } strobe_state_t;
  strobe_state_t state_reg;
  strobe_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.phase = ~state_reg.phase;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // high in the cycle before the divided clock rises
  assign rise_strobe = state_reg.phase;

  phase_alternates_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R07]
    rise_strobe |=> !rise_strobe) else $error("divided clock strobe stuck");
endmodule

/* verification/tb.sv */
// self-checking bench for the clock speed control block
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  import speed_ctrl_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] strap = 8'hFE;
  logic [1:0] mode = 2'h0;
  logic master;
  logic [3:0] cpu_p, wd_p, ca_p, sp_p, t2_p, t1_p, t0_p;
  logic master_d = 1'b0;
  logic changed_d = 1'b0;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  cpu_peripheral_speed_select dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .security_config_byte(strap), .serial_port_mode(mode), .double_speed_master(master),
    .cpu_periods(cpu_p), .watchdog_periods(wd_p), .counter_array_periods(ca_p),
    .serial_port_periods(sp_p), .timer_two_periods(t2_p), .timer_one_periods(t1_p),
    .timer_zero_periods(t0_p));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  task automatic tally_and_finish;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // master must never move on two edges in a row; also the hang limit
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    master_d <= master;
    changed_d <= nrst && (master !== master_d);
    if (nrst && changed_d) `CHK(master, master_d)
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic rst(input logic [7:0] s);
    @(posedge core_clk);
    nrst <= 1'b0;
    strap <= s;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge core_clk);
    #1;
    `CHK(reg_rdata, 8'h00)
  endtask
  function automatic logic [3:0] per(input logic m, input logic b);
    return (m && !b) ? PERIODS_FAST : PERIODS_STANDARD;
  endfunction
  // three edges cover the worst-case wait for the half-rate strobe
  task automatic outs(input logic [7:0] c);
    logic fixed_mode;
    repeat (3) @(posedge core_clk);
    #1;
    fixed_mode = (mode == SERIAL_MODE_SHIFT || mode == SERIAL_MODE_FIXED);
    `CHK(master, c[0])
    `CHK(cpu_p, c[0] ? PERIODS_FAST : PERIODS_STANDARD)
    `CHK(wd_p, per(c[0], c[WATCHDOG_SPEED_POS]))
    `CHK(ca_p, per(c[0], c[COUNTER_ARRAY_SPEED_POS]))
    `CHK(t2_p, per(c[0], c[TIMER_TWO_SPEED_POS]))
    `CHK(t1_p, per(c[0], c[TIMER_ONE_SPEED_POS]))
    `CHK(t0_p, per(c[0], c[TIMER_ZERO_SPEED_POS]))
    `CHK(sp_p, per(c[0] && fixed_mode, c[SERIAL_PORT_SPEED_POS]))
  endtask
  task automatic set(input logic [7:0] c);
    wr(CLOCK_SPEED_CONTROL_ADDR, c);
    outs(c);
    rd(CLOCK_SPEED_CONTROL_ADDR, c & WRITABLE_MASK);
  endtask
  initial begin
    rst(8'hFE);
    rd(CLOCK_SPEED_CONTROL_ADDR, 8'h00);
    outs(8'h00);
    $display("test reset done");
    set(8'h7E);
    set(8'h80);
    set(8'h01);
    for (int p = 1; p < 7; p++) set(8'h01 | (8'h01 << p));
    $display("test unit bits done");
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk);
      mode <= m[1:0];
      set(8'h11);
      set(8'h01);
    end
    $display("test serial modes done");
    set(8'hFF);
    wr(8'h8E, 8'h00);
    rd(CLOCK_SPEED_CONTROL_ADDR, 8'h7F);
    rd(8'h8E, 8'h00);
    $display("test reserved and unmapped done");
    // control flips every cycle; the master follows only on strobe edges
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= CLOCK_SPEED_CONTROL_ADDR;
    reg_wdata <= 8'h00;
    repeat (4) begin
      @(posedge core_clk);
      reg_wdata <= ~reg_wdata & 8'h01;
    end
    @(posedge core_clk);
    reg_write <= 1'b0;
    outs(8'h00);
    $display("test master switching done");
    rst(8'h01);
    rd(CLOCK_SPEED_CONTROL_ADDR, 8'h01);
    outs(8'h01);
    $display("test strap reset done");
    tally_and_finish;
  end
endmodule
